// File: pll_analog_model.sv
module pll_analog_model #(
    parameter logic [15:0] MOD_VALUE = 16'h1234
) (
    // loop side of the sequencer
    input  wire logic   ref_clk_i,
    input  wire logic   resetn_i,
    input  wire logic   divider_reset_i,
    output logic        doubler_clk_o,
    output logic        feedback_cycle_o,
    output logic [15:0] fractional_modulator_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase_cnt;
    logic [1:0] fb_cnt;
    assign fractional_modulator_o = MOD_VALUE;
    // doubler runs free, ten cycles a phase keeps edges far apart;
    // a divider held in reset makes no feedback cycles
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_cnt        <= 4'h0;
            doubler_clk_o    <= 1'b0;
            fb_cnt           <= 2'h0;
            feedback_cycle_o <= 1'b0;
        end else begin
            phase_cnt <= (phase_cnt == 4'h9) ? 4'h0 : phase_cnt + 4'h1;
            doubler_clk_o <= doubler_clk_o ^ (phase_cnt == 4'h9);
            fb_cnt <= divider_reset_i ? 2'h0 : fb_cnt + 2'h1;
            feedback_cycle_o <= !divider_reset_i && fb_cnt == 2'h3;
        end
    end
endmodule

// File: pll_switch_map.svh
`ifndef PLL_SWITCH_MAP_SVH
`define PLL_SWITCH_MAP_SVH

// register byte addresses (word aligned)
`define ADDR_SWITCH_CFG      6'h00
`define ADDR_VCO_DAC_CFG     6'h04
`define ADDR_SEQ_STATUS      6'h08

// reset values and the config write mask
`define SWITCH_CFG_RESET     32'h09E1CF88
`define SWITCH_CFG_WMASK     32'h3FFFFFFF
`define VCO_DAC_RESET        4'h5

// crystal switch configuration fields
`define F_STEP_INTERVAL      29:27
`define F_STEP_SIZE          26:24
`define B_RAMP_EN            23
`define F_CORRECTION         22:19
`define B_CORRECTION_EN      18
`define F_DIV_HOLD_SEL       17:15
`define F_PUMP_HOLD_SEL      14:12
`define B_DIV_RESET_EN       11
`define B_PUMP_GATE_EN       10
`define B_DOWN_LIM_EN        9
`define B_UP_LIM_EN          8
`define F_DOWN_CODE          7:4
`define F_UP_CODE            3:0

// legal hold edge selects
`define EDGE_SEL_MIN         3'h3
`define EDGE_SEL_MAX         3'h6

// feedback cycles that receive the correction
`define CORRECTED_CYCLES     2'h2

// timing: ramp interval unit and clock period
`define RAMP_UNIT_NS         1000
`define CLK_PERIOD_NS        10
`define RAMP_UNIT_CYCLES     ((`RAMP_UNIT_NS) / (`CLK_PERIOD_NS))

`endif

// File: pll_switch_pkg.sv
package pll_switch_pkg;

    // classic wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [5:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    // state of the sequencer except the divide, offset and boost registers
    typedef struct packed {
        logic [31:0] cfg;
        logic [3:0]  dac;
        logic        ack;
        logic [31:0] rdat;
        logic        dbl_s1;
        logic        dbl_s2;
        logic        dbl_d;
        logic        sw_s1;
        logic        sw_s2;
        logic        sw_d;
        logic [2:0]  div_cnt;
        logic [2:0]  pump_cnt;
        logic        div_hold;
        logic        pump_hold;
        logic [1:0]  corr_left;
        logic        ramp_active;
        logic [9:0]  ramp_tick;
    } seq_state_t;

endpackage

// File: pll_switch_properties.sv
module pll_switch_properties (
    // watched ports of the sequencer
    input wire logic                    ref_clk_i,
    input wire logic                    resetn_i,
    input wire pll_switch_pkg::wb_req_t wb_req_i,
    input wire logic                    wb_ack_o,
    input wire logic                    xtal_switch_i,
    input wire logic                    divider_reset_o,
    input wire logic                    pump_disable_o,
    input wire logic [3:0]              down_width_code_o,
    input wire logic [3:0]              up_width_code_o,
    input wire logic [3:0]              vco_dac_code_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // bus answers once, one cycle after the request
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    ack_answer_a: assert property (wb_req_i.cyc && wb_req_i.stb
        && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
    // static codes move only with an acknowledged write
    width_codes_a: assert property (
        !$stable({down_width_code_o, up_width_code_o})
        |-> wb_ack_o && $past(wb_req_i.we)) else $error("width code moved");
    dac_code_a: assert property (
        !$stable(vco_dac_code_o) |-> wb_ack_o && $past(wb_req_i.we))
        else $error("dac code moved");
    div_start_a: assert property (
        $rose(divider_reset_o) |-> $past(xtal_switch_i, 3))
        else $error("divider hold without switch");
    pump_start_a: assert property (
        $rose(pump_disable_o) |-> $past(xtal_switch_i, 3))
        else $error("pump gate without switch");
    // three doubler edges need at least eight ref cycles
    div_min_a: assert property (
        $rose(divider_reset_o) |-> divider_reset_o [*8])
        else $error("divider hold too short");
    // bound assumes the bench doubler of 20 ref cycles a period
    pump_end_a: assert property (
        $rose(pump_disable_o) |-> ##[1:200] !pump_disable_o)
        else $error("pump gate never released");
endmodule
bind pll_switch_sequencer pll_switch_properties u_pll_switch_properties (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o), .xtal_switch_i(xtal_switch_i),
    .divider_reset_o(divider_reset_o), .pump_disable_o(pump_disable_o),
    .down_width_code_o(down_width_code_o), .up_width_code_o(up_width_code_o),
    .vco_dac_code_o(vco_dac_code_o));

// File: pll_switch_sequencer.sv
`include "pll_switch_map.svh"

module pll_switch_sequencer #(
    parameter int MOD_W = 16,
    parameter int OFF_W = 8
) (
    // clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    resetn_i,
    // wishbone slave
    input  wire pll_switch_pkg::wb_req_t wb_req_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // crystal switch and doubler pins
    input  wire logic                    xtal_switch_i,
    input  wire logic                    doubler_clk_i,
    // feedback path, same clock
    input  wire logic [MOD_W-1:0]        fractional_modulator_i,
    input  wire logic                    feedback_cycle_i,
    output logic [MOD_W-1:0]             divide_value_o,
    output logic                         divider_reset_o,
    // charge pump
    input  wire logic [OFF_W-1:0]        pump_offset_cfg_i,
    input  wire logic                    pump_boost_cfg_i,
    output logic                         pump_disable_o,
    output logic [OFF_W-1:0]             pump_offset_o,
    output logic                         pump_boost_o,
    // static analog codes
    output logic                         down_width_limiter_enable_o,
    output logic                         up_width_limiter_enable_o,
    output logic [3:0]                   down_width_code_o,
    output logic [3:0]                   up_width_code_o,
    output logic [3:0]                   vco_dac_code_o
);

    // widths the arithmetic below cannot serve
    if (MOD_W < 5 || OFF_W < 3) begin : g_bad_width
        $error("pll_switch_sequencer: MOD_W >= 5 and OFF_W >= 3 needed");
    end

    pll_switch_pkg::seq_state_t st_reg;
    pll_switch_pkg::seq_state_t st_next;
    logic [MOD_W-1:0]           div_reg;
    logic [MOD_W-1:0]           div_next;
    logic [OFF_W-1:0]           off_reg;
    logic [OFF_W-1:0]           off_next;
    logic                       boost_reg;
    logic                       boost_next;

    logic [31:0]       wmask;
    logic [31:0]       cfg_wr;
    logic              bus_req;
    logic              dbl_edge;
    logic              sw_event;
    logic [2:0]        div_cnt_inc;
    logic [2:0]        pump_cnt_inc;
    logic [MOD_W-1:0]  corr_ext;
    logic [9:0]        tick_last;
    logic [OFF_W:0]    off_sum;

    // byte enables widen into a bit mask
    assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                    {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~st_reg.ack;

    // edges are taken from the second synchroniser stage only
    assign dbl_edge = st_reg.dbl_s2 & ~st_reg.dbl_d;
    assign sw_event = st_reg.sw_s2 & ~st_reg.sw_d;

    assign div_cnt_inc  = st_reg.div_cnt + 3'h1;
    assign pump_cnt_inc = st_reg.pump_cnt + 3'h1;
    assign corr_ext = MOD_W'($signed(st_reg.cfg[`F_CORRECTION]));
    assign tick_last = 10'(`RAMP_UNIT_CYCLES
                           * int'(st_reg.cfg[`F_STEP_INTERVAL]) - 1);
    assign off_sum = {1'b0, off_reg}
                     + (OFF_W+1)'(st_reg.cfg[`F_STEP_SIZE]);

    // next state
    always_comb begin
        st_next    = st_reg;
        div_next   = fractional_modulator_i;
        off_next   = off_reg;
        boost_next = boost_reg;
        cfg_wr     = (st_reg.cfg & ~wmask)
                     | (wb_req_i.dat & wmask & `SWITCH_CFG_WMASK);

        // two-stage synchronisers for the pins
        st_next.dbl_s1 = doubler_clk_i;
        st_next.dbl_s2 = st_reg.dbl_s1;
        st_next.dbl_d  = st_reg.dbl_s2;
        st_next.sw_s1  = xtal_switch_i;
        st_next.sw_s2  = st_reg.sw_s1;
        st_next.sw_d   = st_reg.sw_s2;

        // bus: ack one cycle after the request, dropped the cycle after
        st_next.ack  = bus_req;
        st_next.rdat = 32'h00000000;
        if (bus_req) begin
            unique case (wb_req_i.adr)
                `ADDR_SWITCH_CFG: begin
                    st_next.rdat = st_reg.cfg;
                    if (wb_req_i.we) begin
                        // an illegal hold select keeps the old value
                        if (cfg_wr[`F_DIV_HOLD_SEL] < `EDGE_SEL_MIN ||
                            cfg_wr[`F_DIV_HOLD_SEL] > `EDGE_SEL_MAX) begin
                            cfg_wr[`F_DIV_HOLD_SEL] =
                                st_reg.cfg[`F_DIV_HOLD_SEL];
                        end
                        if (cfg_wr[`F_PUMP_HOLD_SEL] < `EDGE_SEL_MIN ||
                            cfg_wr[`F_PUMP_HOLD_SEL] > `EDGE_SEL_MAX) begin
                            cfg_wr[`F_PUMP_HOLD_SEL] =
                                st_reg.cfg[`F_PUMP_HOLD_SEL];
                        end
                        st_next.cfg = cfg_wr;
                    end
                end
                `ADDR_VCO_DAC_CFG: begin
                    st_next.rdat = {28'h0000000, st_reg.dac};
                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                        st_next.dac = wb_req_i.dat[3:0];
                    end
                end
                `ADDR_SEQ_STATUS: begin
                    st_next.rdat = {17'h00000, st_reg.ramp_active,
                                    st_reg.corr_left, st_reg.pump_cnt,
                                    st_reg.div_cnt, 4'h0,
                                    st_reg.pump_hold, st_reg.div_hold};
                end
                default: begin
                    st_next.rdat = 32'h00000000; // unmapped reads zero
                end
            endcase
        end

        // count doubler edges; release each hold on its selected edge
        if (dbl_edge && st_reg.div_hold) begin
            st_next.div_cnt = div_cnt_inc;
            if (div_cnt_inc == st_reg.cfg[`F_DIV_HOLD_SEL]) begin
                st_next.div_hold = 1'b0;
            end
        end
        if (dbl_edge && st_reg.pump_hold) begin
            st_next.pump_cnt = pump_cnt_inc;
            if (pump_cnt_inc == st_reg.cfg[`F_PUMP_HOLD_SEL]) begin
                st_next.pump_hold = 1'b0;
            end
        end

        // corrected cycles count down once the divider runs again
        if (feedback_cycle_i && !st_reg.div_hold &&
            st_reg.corr_left != 2'h0) begin
            st_next.corr_left = st_reg.corr_left - 2'h1;
        end

        // offset ramp back to the programmed values
        if (st_reg.ramp_active) begin
            st_next.ramp_tick = st_reg.ramp_tick + 10'h001;
            if (st_reg.ramp_tick >= tick_last) begin
                st_next.ramp_tick = 10'h000;
                if (off_reg == pump_offset_cfg_i) begin
                    st_next.ramp_active = 1'b0;
                    boost_next          = pump_boost_cfg_i;
                end else if (off_sum >= {1'b0, pump_offset_cfg_i}) begin
                    off_next = pump_offset_cfg_i;
                end else begin
                    off_next = off_sum[OFF_W-1:0];
                end
            end
        end else begin
            off_next   = pump_offset_cfg_i;
            boost_next = pump_boost_cfg_i;
        end

        // a switchover clears both edge counters and restarts each enabled hold and the ramp; it wins over the steps above
        if (sw_event) begin
            st_next.div_cnt  = 3'h0;
            st_next.pump_cnt = 3'h0;
            if (st_reg.cfg[`B_DIV_RESET_EN]) begin
                st_next.div_hold  = 1'b1;
                st_next.corr_left = `CORRECTED_CYCLES;
            end
            if (st_reg.cfg[`B_PUMP_GATE_EN]) begin
                st_next.pump_hold = 1'b1;
            end
            if (st_reg.cfg[`B_RAMP_EN]) begin
                st_next.ramp_active = 1'b1;
                st_next.ramp_tick   = 10'h000;
                off_next            = '0;
                boost_next          = 1'b0;
            end
        end

        // override only while corrected cycles remain
        if (st_reg.cfg[`B_CORRECTION_EN] && st_reg.corr_left != 2'h0) begin
            div_next = fractional_modulator_i + corr_ext;
        end
    end

    // state registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg     <= '0;
            st_reg.cfg <= `SWITCH_CFG_RESET;
            st_reg.dac <= `VCO_DAC_RESET;
            div_reg    <= '0;
            off_reg    <= '0;
            boost_reg  <= 1'b0;
        end else begin
            st_reg     <= st_next;
            div_reg    <= div_next;
            off_reg    <= off_next;
            boost_reg  <= boost_next;
        end
    end

    // all outputs straight from flip-flops
    assign wb_dat_o        = st_reg.rdat;
    assign wb_ack_o        = st_reg.ack;
    assign divide_value_o  = div_reg;
    assign divider_reset_o = st_reg.div_hold;
    assign pump_disable_o  = st_reg.pump_hold;
    assign pump_offset_o   = off_reg;
    assign pump_boost_o    = boost_reg;
    // limiter enables are software's to sequence around lock
    assign down_width_limiter_enable_o = st_reg.cfg[`B_DOWN_LIM_EN];
    assign up_width_limiter_enable_o   = st_reg.cfg[`B_UP_LIM_EN];
    assign down_width_code_o = st_reg.cfg[`F_DOWN_CODE];
    assign up_width_code_o   = st_reg.cfg[`F_UP_CODE];
    assign vco_dac_code_o    = st_reg.dac;

endmodule

// File: pll_xtal_switch_sequencer_tb.sv
`include "pll_switch_map.svh"
module pll_xtal_switch_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MOD = 16'h1234;
    logic                    ref_clk_i = 1'b0;
    logic                    resetn_i = 1'b0;
    logic                    xtal = 1'b0;
    pll_switch_pkg::wb_req_t wb_req = '0;
    logic [31:0]             rdat;
    logic [15:0]             modv, divv;
    logic [7:0]              offs;
    logic [3:0]              dn_code, up_code, dac;
    logic                    ack, dbl, fbp, drst, pdis, boost, dn_en, up_en;
    int                      err_count = 0;
    int                      checks = 0;
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    pll_switch_sequencer u_pll_switch_sequencer (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_req_i(wb_req),
        .wb_dat_o(rdat), .wb_ack_o(ack), .xtal_switch_i(xtal),
        .doubler_clk_i(dbl), .fractional_modulator_i(modv),
        .feedback_cycle_i(fbp), .divide_value_o(divv),
        .divider_reset_o(drst), .pump_offset_cfg_i(8'h05),
        .pump_boost_cfg_i(1'b1), .pump_disable_o(pdis),
        .pump_offset_o(offs), .pump_boost_o(boost),
        .down_width_limiter_enable_o(dn_en),
        .up_width_limiter_enable_o(up_en), .down_width_code_o(dn_code),
        .up_width_code_o(up_code), .vco_dac_code_o(dac));
    pll_analog_model #(.MOD_VALUE(MOD)) u_pll_analog_model (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .divider_reset_i(drst),
        .doubler_clk_o(dbl), .feedback_cycle_o(fbp),
        .fractional_modulator_o(modv));
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // classic single cycle; entered just after a rising edge
    task automatic wb(input logic we, input logic [5:0] adr,
                      input logic [31:0] wd, output logic [31:0] rd);
        int n;
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, wd};
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge ref_clk_i);
        if (ack !== 1'b1) begin
            err_count++;
            summarize();
        end
        rd = rdat;
        wb_req <= '0;
        @(posedge ref_clk_i);
    endtask
    task automatic t_registers();
        logic [31:0] rd;
        logic [31:0] cv;
        wb(1'b0, `ADDR_SWITCH_CFG, 32'h0, rd);
        chk("cfg reset", 32'h09E1CF88, rd);
        wb(1'b0, `ADDR_VCO_DAC_CFG, 32'h0, rd);
        chk("dac reset", 32'h5, rd);
        cv = {18'h0, dn_en, up_en, dn_code, up_code, dac};
        chk("reset codes", 32'h00003885, cv);
        wb(1'b1, `ADDR_SWITCH_CFG, 32'h09E1CC3A, rd);
        cv = {18'h0, dn_en, up_en, dn_code, up_code, dac};
        chk("limiters", 32'h000003A5, cv);
        // selects outside 3..6 and the two top bits are refused
        wb(1'b1, `ADDR_SWITCH_CFG, 32'hC9E3AC3A, rd);
        wb(1'b0, `ADDR_SWITCH_CFG, 32'h0, rd);
        chk("illegal selects", 32'h09E1CC3A, rd);
        wb(1'b1, `ADDR_VCO_DAC_CFG, 32'hF, rd);
        chk("dac top code", 32'hF, {28'h0, dac});
        wb(1'b0, 6'h3C, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
    endtask
    // switch right after a doubler rise so no edge slips in early
    task automatic sw_run(input logic [31:0] cfg, input int div_n, pump_n,
                          input logic [15:0] first);
        logic [31:0] rd;
        logic        dq, rq, seen;
        int          dn, pn, i;
        dq = 1'b1;
        rq = 1'b0;
        seen = 1'b0;
        dn = 0;
        pn = 0;
        wb(1'b1, `ADDR_SWITCH_CFG, cfg, rd);
        for (i = 0; i < 40 && !(dbl && !dq); i++) begin
            dq = dbl;
            @(posedge ref_clk_i);
        end
        if (i >= 40) begin
            err_count++;
            summarize();
        end
        xtal <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge ref_clk_i);
            dn += (dbl && !dq && drst) ? 1 : 0;
            pn += (dbl && !dq && pdis) ? 1 : 0;
            if (rq && !drst) chk("corrected divide", first, divv);
            if (pdis && !seen && cfg[`B_RAMP_EN])
                chk("ramp start", 32'h0, offs);
            seen |= pdis;
            dq = dbl;
            rq = drst;
        end
        chk("divider edges", div_n, dn);
        chk("pump edges", pump_n, pn);
        chk("settled divide", MOD, divv);
        xtal <= 1'b0;
        // ramp of five unit steps plus one interval ends by 600 cycles
        repeat (800) @(posedge ref_clk_i);
        chk("ramp end", 32'h105, {boost, offs});
        // counters keep their final counts once both holds are over
        wb(1'b0, `ADDR_SEQ_STATUS, 32'h0, rd);
        chk("status", (pump_n << 9) | (div_n << 6), rd);
    endtask
    // defaults: divider waits for edge 3, pump for edge 4, no correction
    task automatic t_default_switch();
        sw_run(32'h09E1CF88, 3, 4, MOD);
    endtask
    // longest divider hold with a negative correction
    task automatic t_negative_correction();
        sw_run(32'h09E73F88, 6, 3, MOD - 16'h4);
    endtask
    // longest pump hold with a positive correction
    task automatic t_positive_correction();
        sw_run(32'h09BEEF88, 5, 6, MOD + 16'h7);
    endtask
    // divider reset disabled: no hold and no correction armed
    task automatic t_no_divider_reset();
        sw_run(32'h09E1C788, 0, 4, MOD);
    endtask
    // pump gating disabled: pump never held
    task automatic t_no_pump_gate();
        sw_run(32'h09E1CB88, 3, 0, MOD);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        t_registers();
        t_default_switch();
        t_negative_correction();
        t_positive_correction();
        t_no_divider_reset();
        t_no_pump_gate();
        summarize();
    end
endmodule
